// >>> i2c_tx_pkg.sv
// Shared constants for the two-wire master transmit engine
package i2c_tx_pkg;
  // Operation codes passed from the system side to the link side
  localparam logic [1:0] OP_START = 2'h0;
  localparam logic [1:0] OP_RSTART = 2'h1;
  localparam logic [1:0] OP_STOP = 2'h2;
  localparam logic [1:0] OP_BYTE = 2'h3;
  // Byte framing
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam int MSB = 7;
  // Link timing: SDA moves one link cycle more than this count after SCL falls
  localparam logic [15:0] SDA_DELAY = 16'h0001;
  localparam int LINK_PERIOD_NS = 80;
  localparam int START_HOLD_NS = 4000;
  localparam int START_HOLD_CYC = (START_HOLD_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam logic [15:0] START_HOLD_M1 = 16'(START_HOLD_CYC - 1);
  // Defaults
  localparam int BAUD_DEFAULT = 10;
  localparam int FIFO_DEPTH = 16;
  localparam int DATA_W = 8;
  localparam logic [7:0] BUF_RESET = 8'h00;
endpackage : i2c_tx_pkg

// >>> byte_fifo_if.sv
// Valid/ready carrier between the FIFO and its user
`timescale 1ns/1ps
interface byte_fifo_if #(parameter int WIDTH = 8) ();
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  modport fifo (input in_valid, input in_data, input out_ready,
                output in_ready, output out_valid, output out_data);
  modport user (output in_valid, output in_data, output out_ready,
                input in_ready, input out_valid, input out_data);
endinterface : byte_fifo_if

// >>> byte_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  byte_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic push;
  logic pop;
  logic full;
  logic empty;

  // Extra pointer bit tells full from empty
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign f.in_ready = !full;
  assign f.out_valid = !empty;
  assign f.out_data = mem[rd_ptr[AW-1:0]];
  assign push = f.in_valid && !full;
  assign pop = f.out_ready && !empty;

  // Pointer next values
  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  // Pointers and storage
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= f.in_data;
    end
  end
endmodule : byte_fifo

// >>> i2c_master_transmit.sv
// Two-wire master transmit engine: software side on CLK_SYS, bus side on CLK_LINK
`timescale 1ns/1ps
module i2c_master_transmit #(
  parameter int BAUD_PERIOD = i2c_tx_pkg::BAUD_DEFAULT,
  parameter int FIFO_DEPTH = i2c_tx_pkg::FIFO_DEPTH
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CLK_LINK,
  input wire logic BUF_WR,
  input wire logic [7:0] BUF_WDATA,
  input wire logic TX_VALID,
  input wire logic [7:0] TX_DATA,
  output logic TX_READY,
  input wire logic START_REQ,
  input wire logic RSTART_REQ,
  input wire logic STOP_REQ,
  input wire logic IRQ_CLR,
  input wire logic WRITE_COLLISION_FLAG_CLR,
  output logic START_COND_ENABLE,
  output logic REPEATED_START_ENABLE,
  output logic STOP_COND_ENABLE,
  output logic BUFFER_FULL_FLAG,
  output logic WRITE_COLLISION_FLAG,
  output logic ACK_STATUS_FLAG,
  output logic SERIAL_PORT_IRQ_FLAG,
  output logic [7:0] TX_BUFFER_REG,
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE
);
  localparam logic [15:0] BAUD_M1 = 16'(BAUD_PERIOD - 1);

  typedef enum logic [8:0] {
    L_IDLE = 9'h001, L_START = 9'h002, L_RS_SDA = 9'h004, L_RS_SCL = 9'h008,
    L_SP_LOW = 9'h010, L_SP_SCL = 9'h020, L_SP_SDA = 9'h040,
    L_BIT_LOW = 9'h080, L_BIT_HIGH = 9'h100
  } link_state_e;

  // System domain: software-visible flags, buffer and byte queue
  byte_fifo_if #(.WIDTH(i2c_tx_pkg::DATA_W)) fq ();
  byte_fifo #(.WIDTH(i2c_tx_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK_SYS),
    .rst(RST),
    .f(fq)
  );

  logic busy, next_busy;
  logic bf, next_bf;
  logic write_collision_flag, next_write_collision_flag;
  logic ack, next_ack;
  logic irq, next_irq;
  logic st_pend, next_st_pend;
  logic rs_pend, next_rs_pend;
  logic sp_pend, next_sp_pend;
  logic [7:0] tx_buffer_reg, next_tx_buffer_reg;
  logic [1:0] cur_op, next_cur_op;
  logic req_tgl, next_req_tgl;
  logic [2:0] done_sync;
  logic [2:0] bfc_sync;
  logic done_evt;
  logic bfc_evt;
  logic byte_ok;
  logic fifo_pop;
  logic wr_ok;
  logic ack_lnk;

  assign fq.in_valid = TX_VALID;
  assign fq.in_data = TX_DATA;
  assign TX_READY = fq.in_ready;
  assign done_evt = done_sync[2] ^ done_sync[1];
  assign bfc_evt = bfc_sync[2] ^ bfc_sync[1];
  // A byte is only taken when no operation is on the bus and no condition waits
  assign byte_ok = !busy && !st_pend && !rs_pend && !sp_pend;
  // Queue is drained only once software has serviced the last interrupt
  assign fifo_pop = byte_ok && !BUF_WR && !irq && fq.out_valid;
  assign fq.out_ready = fifo_pop;
  assign wr_ok = (BUF_WR || fifo_pop) && byte_ok;

  // Next values of the software-visible state
  always_comb begin
    next_busy = busy;
    next_bf = bf;
    next_write_collision_flag = write_collision_flag && !WRITE_COLLISION_FLAG_CLR;
    next_ack = ack;
    next_irq = irq && !IRQ_CLR;
    next_st_pend = st_pend || START_REQ;
    next_rs_pend = rs_pend || RSTART_REQ;
    next_sp_pend = sp_pend || STOP_REQ;
    next_tx_buffer_reg = tx_buffer_reg;
    next_cur_op = cur_op;
    next_req_tgl = req_tgl;
    if (bfc_evt) begin
      next_bf = 1'b0;
    end
    if (done_evt) begin
      next_busy = 1'b0;
      next_irq = 1'b1;
      case (cur_op)
        i2c_tx_pkg::OP_START: next_st_pend = 1'b0;
        i2c_tx_pkg::OP_RSTART: next_rs_pend = 1'b0;
        i2c_tx_pkg::OP_STOP: next_sp_pend = 1'b0;
        default: next_ack = ack_lnk;
      endcase
    end else if (!busy && (st_pend || rs_pend || sp_pend)) begin
      // Conditions go out in start, restart, stop priority
      next_busy = 1'b1;
      next_req_tgl = !req_tgl;
      if (st_pend) begin
        next_cur_op = i2c_tx_pkg::OP_START;
      end else if (rs_pend) begin
        next_cur_op = i2c_tx_pkg::OP_RSTART;
      end else begin
        next_cur_op = i2c_tx_pkg::OP_STOP;
      end
    end else if (wr_ok) begin
      next_tx_buffer_reg = BUF_WR ? BUF_WDATA : fq.out_data;
      next_bf = 1'b1;
      next_busy = 1'b1;
      next_cur_op = i2c_tx_pkg::OP_BYTE;
      next_req_tgl = !req_tgl;
    end
    if (BUF_WR && !byte_ok) begin
      next_write_collision_flag = 1'b1;
    end
  end

  // Software-visible state registers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      busy <= 1'b0;
      bf <= 1'b0;
      write_collision_flag <= 1'b0;
      ack <= 1'b0;
      irq <= 1'b0;
      st_pend <= 1'b0;
      rs_pend <= 1'b0;
      sp_pend <= 1'b0;
      tx_buffer_reg <= i2c_tx_pkg::BUF_RESET;
      cur_op <= i2c_tx_pkg::OP_START;
      req_tgl <= 1'b0;
    end else begin
      busy <= next_busy;
      bf <= next_bf;
      write_collision_flag <= next_write_collision_flag;
      ack <= next_ack;
      irq <= next_irq;
      st_pend <= next_st_pend;
      rs_pend <= next_rs_pend;
      sp_pend <= next_sp_pend;
      tx_buffer_reg <= next_tx_buffer_reg;
      cur_op <= next_cur_op;
      req_tgl <= next_req_tgl;
    end
  end

  assign START_COND_ENABLE = st_pend;
  assign REPEATED_START_ENABLE = rs_pend;
  assign STOP_COND_ENABLE = sp_pend;
  assign BUFFER_FULL_FLAG = bf;
  assign WRITE_COLLISION_FLAG = write_collision_flag;
  assign ACK_STATUS_FLAG = ack;
  assign SERIAL_PORT_IRQ_FLAG = irq;
  assign TX_BUFFER_REG = tx_buffer_reg;

  // Link domain: bus sequencer and pin synchronisers
  link_state_e state, next_state;
  logic [1:0] rst_sync;
  logic link_rst;
  logic [2:0] req_sync;
  logic [1:0] sda_sync;
  logic [1:0] scl_sync;
  logic [15:0] cnt, next_cnt;
  logic [3:0] bitn, next_bitn;
  logic [7:0] shreg, next_shreg;
  logic scl_oe, next_scl_oe;
  logic sda_oe, next_sda_oe;
  logic ack_bit, next_ack_bit;
  logic done_tgl, next_done_tgl;
  logic bfc_tgl, next_bfc_tgl;
  logic req_evt;
  logic tick;

  assign link_rst = rst_sync[1];
  assign req_evt = req_sync[2] ^ req_sync[1];
  assign tick = (cnt == BAUD_M1);
  // Read only after the done toggle has crossed, so it is stable by then
  assign ack_lnk = ack_bit;

  // Bus sequencer: each phase except the start hold counts one baud period on the link clock
  always_comb begin
    next_state = state;
    next_cnt = cnt + 16'h0001;
    next_bitn = bitn;
    next_shreg = shreg;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    next_ack_bit = ack_bit;
    next_done_tgl = done_tgl;
    next_bfc_tgl = bfc_tgl;
    case (state)
      L_IDLE: begin
        // Baud count stays parked here, SCL held as left
        next_cnt = 16'h0000;
        if (req_evt) begin
          case (cur_op)
            i2c_tx_pkg::OP_START: begin
              next_sda_oe = 1'b1;
              next_state = L_START;
            end
            i2c_tx_pkg::OP_RSTART: begin
              next_sda_oe = 1'b0;
              next_state = L_RS_SDA;
            end
            i2c_tx_pkg::OP_STOP: begin
              next_sda_oe = 1'b1;
              next_state = L_SP_LOW;
            end
            default: begin
              next_shreg = tx_buffer_reg;
              next_bitn = 4'h0;
              next_state = L_BIT_LOW;
            end
          endcase
        end
      end
      L_START: begin
        if (cnt == i2c_tx_pkg::START_HOLD_M1) begin
          next_scl_oe = 1'b1;
          next_done_tgl = !done_tgl;
          next_state = L_IDLE;
        end
      end
      L_RS_SDA: if (tick) begin
        next_scl_oe = 1'b0;
        next_cnt = 16'h0000;
        next_state = L_RS_SCL;
      end
      L_RS_SCL: begin
        if (!scl_sync[1]) begin
          next_cnt = 16'h0000; // Slave stretching the clock
        end else if (tick) begin
          next_sda_oe = 1'b1;
          next_cnt = 16'h0000;
          next_state = L_START;
        end
      end
      L_SP_LOW: if (tick) begin
        next_scl_oe = 1'b0;
        next_cnt = 16'h0000;
        next_state = L_SP_SCL;
      end
      L_SP_SCL: if (tick) begin
        next_sda_oe = 1'b0;
        next_cnt = 16'h0000;
        next_state = L_SP_SDA;
      end
      L_SP_SDA: if (tick) begin
        next_done_tgl = !done_tgl;
        next_state = L_IDLE;
      end
      L_BIT_LOW: begin
        // SDA moves two cycles after SCL fell, never while SCL is high
        if (cnt == i2c_tx_pkg::SDA_DELAY) begin
          next_sda_oe = (bitn == i2c_tx_pkg::ACK_BIT) ? 1'b0 : !shreg[i2c_tx_pkg::MSB];
        end
        if (tick) begin
          next_scl_oe = 1'b0;
          next_cnt = 16'h0000;
          next_state = L_BIT_HIGH;
        end
      end
      L_BIT_HIGH: begin
        if (!scl_sync[1]) begin
          next_cnt = 16'h0000;
        end else if (tick) begin
          next_scl_oe = 1'b1;
          next_cnt = 16'h0000;
          if (bitn == i2c_tx_pkg::ACK_BIT) begin
            next_ack_bit = sda_sync[1];
            next_done_tgl = !done_tgl;
            next_state = L_IDLE;
          end else begin
            if (bitn == i2c_tx_pkg::LAST_DATA_BIT) begin
              next_bfc_tgl = !bfc_tgl;
            end
            next_shreg = {shreg[6:0], 1'b0};
            next_bitn = bitn + 4'h1;
            next_state = L_BIT_LOW;
          end
        end
      end
      default: next_state = L_IDLE;
    endcase
  end

  // Link registers; pins and requests pass two flops before use
  always_ff @(posedge CLK_LINK) begin
    rst_sync <= {rst_sync[0], RST};
    sda_sync <= {sda_sync[0], SDA_IN};
    scl_sync <= {scl_sync[0], SCL_IN};
    if (link_rst) begin
      state <= L_IDLE;
      req_sync <= 3'h0;
      cnt <= 16'h0000;
      bitn <= 4'h0;
      shreg <= 8'h00;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      ack_bit <= 1'b0;
      done_tgl <= 1'b0;
      bfc_tgl <= 1'b0;
    end else begin
      state <= next_state;
      req_sync <= {req_sync[1:0], req_tgl};
      cnt <= next_cnt;
      bitn <= next_bitn;
      shreg <= next_shreg;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      ack_bit <= next_ack_bit;
      done_tgl <= next_done_tgl;
      bfc_tgl <= next_bfc_tgl;
    end
  end

  // Completion toggles back into the system domain
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      done_sync <= 3'h0;
      bfc_sync <= 3'h0;
    end else begin
      done_sync <= {done_sync[1:0], done_tgl};
      bfc_sync <= {bfc_sync[1:0], bfc_tgl};
    end
  end

  // Open-drain pins only ever pull low
  assign SCL_OUT = 1'b0;
  assign SCL_OE = scl_oe;
  assign SDA_OUT = 1'b0;
  assign SDA_OE = sda_oe;

  // Assertions and covers
  a_write_collision_flag_on_busy: assert property (@(posedge CLK_SYS) disable iff (RST)
    BUF_WR && !byte_ok |=> write_collision_flag && $stable(tx_buffer_reg))
    else $error("collision write not flagged or buffer changed");
  a_bf_on_write: assert property (@(posedge CLK_SYS) disable iff (RST)
    wr_ok && !done_evt && !(!busy && (st_pend || rs_pend || sp_pend)) |=> bf && busy)
    else $error("buffer write did not set buffer full");
  a_irq_sticky: assert property (@(posedge CLK_SYS) disable iff (RST)
    irq && !IRQ_CLR |=> irq)
    else $error("interrupt flag dropped without clear");
  a_done_sets_irq: assert property (@(posedge CLK_SYS) disable iff (RST)
    done_evt |=> irq && !busy)
    else $error("completion did not raise interrupt flag");
  a_ack_capture: assert property (@(posedge CLK_SYS) disable iff (RST)
    done_evt && cur_op == i2c_tx_pkg::OP_BYTE |=> ack == $past(ack_lnk))
    else $error("ack status does not match ninth bit");
  a_sda_scl_low: assert property (@(posedge CLK_LINK) disable iff (link_rst)
    (state == L_BIT_LOW) && $changed(sda_oe) |-> scl_oe && $past(scl_oe, 2))
    else $error("data moved while clock not low");
  a_sda_stable_high: assert property (@(posedge CLK_LINK) disable iff (link_rst)
    state == L_BIT_HIGH && $past(state) == L_BIT_HIGH |-> $stable(sda_oe))
    else $error("data changed during clock high");
  a_ack_release: assert property (@(posedge CLK_LINK) disable iff (link_rst)
    state == L_BIT_LOW && bitn == i2c_tx_pkg::ACK_BIT && cnt > i2c_tx_pkg::SDA_DELAY
    |-> !sda_oe)
    else $error("master did not release data for ack");
  a_start_hold: assert property (@(posedge CLK_LINK) disable iff (link_rst)
    state == L_START && $past(state) != L_START |-> !scl_oe [*8])
    else $error("clock pulled before start hold elapsed");
  c_byte_ack: cover property (@(posedge CLK_SYS) disable iff (RST)
    done_evt && cur_op == i2c_tx_pkg::OP_BYTE && !ack_lnk);
  c_byte_nack: cover property (@(posedge CLK_SYS) disable iff (RST)
    done_evt && cur_op == i2c_tx_pkg::OP_BYTE && ack_lnk);
  c_collision: cover property (@(posedge CLK_SYS) disable iff (RST) BUF_WR && busy);
  c_stop_done: cover property (@(posedge CLK_SYS) disable iff (RST)
    done_evt && cur_op == i2c_tx_pkg::OP_STOP);
endmodule : i2c_master_transmit

// >>> i2c_slave_model.sv
// Behavioural addressed slave on the two-wire bus
`timescale 1ns/1ps
module i2c_slave_model #(
  parameter logic [6:0] OWN_ADDR = 7'h2a,
  parameter int STRETCH_NS = 600
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_data,
  input wire logic stretch,
  output logic scl_oe,
  output logic sda_oe,
  output logic [7:0] last_byte,
  output int nbit,
  output int n_start,
  output int n_stop
);
  logic [7:0] shift = 8'h00;
  logic first = 1'b0;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    last_byte = 8'h00;
    nbit = 0;
    n_start = 0;
    n_stop = 0;
  end
  // Conditions are SDA edges while SCL is high; both restart the bit count
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      n_start++;
      nbit = 0;
      first = 1'b1;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      n_stop++;
      nbit = 0;
    end
  end
  // Bits are taken while SCL is high, most significant first
  always @(posedge scl) begin
    if (nbit < 8) shift = {shift[6:0], sda};
    nbit++;
  end
  // Ninth bit: answer own address or a good byte, release at its end
  always @(negedge scl) begin
    if (nbit == 8) begin
      last_byte = shift;
      sda_oe = first ? (shift[7:1] == OWN_ADDR) : ack_data;
      first = 1'b0;
    end else if (nbit == 9) begin
      sda_oe = 1'b0;
      nbit = 0;
    end
    // Slow slave: hold SCL low a while so the master must wait
    if (stretch) begin
      scl_oe = 1'b1;
      #(STRETCH_NS);
      scl_oe = 1'b0;
    end
  end
endmodule : i2c_slave_model

// >>> tb_i2c_master_transmit.sv
// Self-checking bench for the two-wire master transmit engine
`timescale 1ns/1ps
module tb_i2c_master_transmit;
  localparam int B = 4;
  localparam logic [6:0] ADDR = 7'h2a;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst = 1'b1;
  logic buf_wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic start_req = 1'b0;
  logic rstart_req = 1'b0;
  logic stop_req = 1'b0;
  logic irq_clr = 1'b0;
  logic write_collision_flag_clr = 1'b0;
  logic ack_data = 1'b1;
  logic stretch = 1'b0;
  logic in_byte = 1'b0;
  logic tx_ready, en_s, en_r, en_p, bf, write_collision_flag, ack, irq;
  logic scl_oe, sda_oe, s_scl_oe, s_sda_oe;
  logic [7:0] buf_reg, last_byte;
  logic scl_out, sda_out;
  int nbit, n_start, n_stop;
  int n_fail = 0;
  int total_checks = 0;
  realtime t_edge = 0;
  realtime t_st = 0;
  // Both lines have pull-ups: released means high
  wire scl = ~(scl_oe | s_scl_oe);
  wire sda = ~(sda_oe | s_sda_oe);

  always #25 clk_sys = ~clk_sys;
  // Link clock: 80 ns period, its rising edges never meet the system clock rising edges
  always #40 clk_link = ~clk_link;

  i2c_master_transmit #(.BAUD_PERIOD(B), .FIFO_DEPTH(16)) u_dut (
    .CLK_SYS(clk_sys), .RST(rst), .CLK_LINK(clk_link), .BUF_WR(buf_wr),
    .BUF_WDATA(wdata), .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_READY(tx_ready),
    .START_REQ(start_req), .RSTART_REQ(rstart_req), .STOP_REQ(stop_req),
    .IRQ_CLR(irq_clr), .WRITE_COLLISION_FLAG_CLR(write_collision_flag_clr), .START_COND_ENABLE(en_s),
    .REPEATED_START_ENABLE(en_r), .STOP_COND_ENABLE(en_p), .BUFFER_FULL_FLAG(bf),
    .WRITE_COLLISION_FLAG(write_collision_flag), .ACK_STATUS_FLAG(ack), .SERIAL_PORT_IRQ_FLAG(irq),
    .TX_BUFFER_REG(buf_reg), .SCL_IN(scl), .SCL_OUT(scl_out), .SCL_OE(scl_oe),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe));

  i2c_slave_model #(.OWN_ADDR(ADDR)) u_slave (.scl(scl), .sda(sda),
    .ack_data(ack_data), .stretch(stretch), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe),
    .last_byte(last_byte), .nbit(nbit), .n_start(n_start), .n_stop(n_stop));

  task summarize;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // One-cycle pulse: 0 start, 1 restart, 2 stop, 3 irq clear, 4 write_collision_flag clear, 5 write
  task pulse(input int k);
    @(negedge clk_sys);
    {start_req, rstart_req, stop_req, irq_clr, write_collision_flag_clr, buf_wr} = 6'h20 >> k;
    @(negedge clk_sys);
    {start_req, rstart_req, stop_req, irq_clr, write_collision_flag_clr, buf_wr} = 6'h00;
  endtask : pulse

  // Bounded wait on the buffer-full or interrupt flag
  task wait_sig(input logic use_bf, input logic v);
    int i;
    for (i = 0; i < 5000; i++) begin
      if ((use_bf ? bf : irq) === v) break;
      @(negedge clk_sys);
    end
    if (i == 5000) begin
      n_fail++;
      $display("BAD %0t wait ran out", $time);
      summarize();
    end
  endtask : wait_sig

  task t_cond(input int k);
    int s0, p0;
    s0 = n_start;
    p0 = n_stop;
    pulse(k);
    chk({en_s, en_r, en_p}, 3'h4 >> k);
    wait_sig(1'b0, 1'b1);
    chk({en_s, en_r, en_p}, 3'h0);
    chk(8'(n_start - s0), 8'(k < 2));
    chk(8'(n_stop - p0), 8'(k == 2));
    if (k == 2) chk({scl, sda}, 2'h3);
    pulse(3);
    chk(irq, 1'b0);
  endtask : t_cond

  // Load, collide, shift, acknowledge and complete one byte
  task t_byte(input logic [7:0] d, input logic ackd, input logic nack);
    ack_data = ackd;
    in_byte = 1'b1;
    wdata = d;
    pulse(5);
    chk(bf, 1'b1);
    chk(buf_reg, d);
    wdata = ~d;
    pulse(5);
    chk(write_collision_flag, 1'b1);
    chk(buf_reg, d);
    pulse(4);
    chk(write_collision_flag, 1'b0);
    wait_sig(1'b1, 1'b0);
    chk(8'(nbit), 8'h08);
    chk(irq, 1'b0);
    wait_sig(1'b0, 1'b1);
    chk(last_byte, d);
    chk(ack, nack);
    repeat (20) @(negedge clk_sys);
    chk({irq, scl, sda}, 3'h5);
    in_byte = 1'b0;
    pulse(3);
  endtask : t_byte

  // Fill the FIFO behind a byte in flight, then drain it against a slow slave
  task t_fifo;
    int n;
    n = 0;
    ack_data = 1'b1;
    in_byte = 1'b1;
    wdata = {ADDR, 1'b0};
    pulse(5);
    repeat (20) begin
      tx_valid = tx_ready;
      tx_data = 8'h40 + 8'(n);
      if (tx_ready) n++;
      @(negedge clk_sys);
    end
    tx_valid = 1'b0;
    chk(8'(n), 8'h10);
    chk(tx_ready, 1'b0);
    stretch = 1'b1;
    wait_sig(1'b0, 1'b1);
    chk(last_byte, {ADDR, 1'b0});
    for (int i = 0; i < 16; i++) begin
      pulse(3);
      wait_sig(1'b0, 1'b1);
      chk(last_byte, 8'h40 + 8'(i));
      chk(ack, 1'b0);
    end
    chk(tx_ready, 1'b1);
    stretch = 1'b0;
    in_byte = 1'b0;
    pulse(3);
  endtask : t_fifo

  // Flags, buffer and pins idle once reset has reached both domains
  task t_reset;
    repeat (10) @(negedge clk_sys);
    chk({1'b0, en_s, en_r, en_p, bf, write_collision_flag, ack, irq}, 8'h00);
    chk(buf_reg, 8'h00);
    chk({tx_ready, scl, sda, scl_out, sda_out}, 5'h1c);
  endtask : t_reset

  // Reset held long enough to reach the link domain too
  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    t_reset();
    t_cond(0);
    t_byte({ADDR, 1'b0}, 1'b0, 1'b0);
    t_byte(8'h5a, 1'b0, 1'b1);
    t_byte(8'ha5, 1'b1, 1'b0);
    t_cond(1);
    t_byte({7'h13, 1'b1}, 1'b1, 1'b1);
    t_cond(1);
    t_fifo();
    t_cond(2);
    summarize();
  end

  // Within a byte SDA may only move while SCL is low
  always @(sda) if (in_byte) chk(scl, 1'b0);
  // Each SCL phase lasts at least one baud period
  always @(scl) begin
    if (in_byte && t_edge > 0) chk(($realtime - t_edge) >= (B * 80 - 1), 1'b1);
    t_edge = $realtime;
  end
  // Start hold: first SCL fall comes no sooner than 4000 ns after SDA fell
  always @(negedge sda) if (scl === 1'b1) t_st = $realtime;
  always @(negedge scl) begin
    if (t_st > 0) chk(($realtime - t_st) >= 3999, 1'b1);
    t_st = 0;
  end
endmodule : tb_i2c_master_transmit
